// ### pkg/tfc_pkg.sv
// trace capture package: register offsets, field positions, reset values,
// run states and entry layout shared by the trace capture design files
// assumes a 32-bit apb slave with byte addresses and a 17-bit core address
package tfc_pkg;
  // ********************************************
  // geometry
  // ********************************************
  localparam int TFC_ADDR_W = 17; // core address width
  localparam int TFC_ENTRY_W = 18; // paged flag plus address
  localparam int TFC_DEPTH = 8; // trace buffer depth
  localparam int TFC_CNT_W = 4; // valid entry count width
  localparam int TFC_PADDR_W = 8; // apb address width
  localparam logic [16:0] TFC_BR_BACK = 17'h00002; // branch source offset

  // ********************************************
  // register byte offsets
  // ********************************************
  localparam logic [7:0] TFC_OFS_CA_EXT = 8'h00;
  localparam logic [7:0] TFC_OFS_CA_HIGH = 8'h04;
  localparam logic [7:0] TFC_OFS_CA_LOW = 8'h08;
  localparam logic [7:0] TFC_OFS_TR_EXT = 8'h0C;
  localparam logic [7:0] TFC_OFS_TR_HIGH = 8'h10;
  localparam logic [7:0] TFC_OFS_TR_LOW = 8'h14;
  localparam logic [7:0] TFC_OFS_CTRL = 8'h18;
  localparam logic [7:0] TFC_OFS_TRIG = 8'h1C;
  localparam logic [7:0] TFC_OFS_STAT = 8'h20;
  localparam logic [7:0] TFC_OFS_CNT = 8'h24;

  // ********************************************
  // field positions
  // ********************************************
  localparam int TFC_CTRL_EN = 7; // module_enable
  localparam int TFC_CTRL_ARM = 6; // arm control
  localparam int TFC_CTRL_TAG = 5; // tag-type breakpoint
  localparam int TFC_CTRL_BRK = 4; // breakpoint_enable
  localparam int TFC_TRIG_SEL = 7; // opcode_qualify_select
  localparam int TFC_TRIG_BEGIN = 6; // begin-trigger type
  localparam int TFC_STAT_AF = 7; // comp_a_match_flag
  localparam int TFC_STAT_BF = 6; // comp_b_match_flag
  localparam int TFC_STAT_CF = 5; // third_status_flag
  localparam int TFC_STAT_TRACE_ACTIVE_FLAG = 0; // trace_active_flag

  // ********************************************
  // reset values and mode codes
  // ********************************************
  localparam logic [7:0] TFC_CTRL_RST = 8'hC0;
  localparam logic [7:0] TFC_TRIG_RST = 8'h40;
  localparam logic [7:0] TFC_CA_EXT_RST = 8'h00;
  localparam logic [7:0] TFC_CA_HIGH_RST = 8'hFF;
  localparam logic [7:0] TFC_CA_LOW_RST = 8'hFE;
  localparam logic [3:0] TFC_MODE_EVT_B = 4'h3;
  localparam logic [3:0] TFC_MODE_A_EVT_B = 4'h4;

  // run states of the trace controller
  typedef enum logic [1:0] {
    TFC_RUN_IDLE = 2'b00, // not armed
    TFC_RUN_WAIT = 2'b01, // begin run, waiting for trigger
    TFC_RUN_FILL = 2'b10, // begin run, capturing
    TFC_RUN_END = 2'b11 // end run, capturing until trigger
  } tfc_run_t;
endpackage

// ### hdl/tfc_cof_addr.sv
// change-of-flow address former for the trace capture block
// assumes core address, paged flag and flow indicators valid every clock
`timescale 1ns/1ps
module tfc_cof_addr
  import tfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [tfc_pkg::TFC_ADDR_W-1:0] core_addr,
  input wire logic core_paged,
  input wire logic [1:0] core_cof,
  output logic cof_valid,
  output logic [tfc_pkg::TFC_ENTRY_W-1:0] cof_entry
);
  import tfc_pkg::*;

  // previous-cycle address, kept for taken branches
  typedef struct packed {
    logic [TFC_ADDR_W-1:0] prev_addr;
    logic prev_paged;
  } tfc_cof_st_t;

  tfc_cof_st_t st_reg; // registered state
  tfc_cof_st_t st_next; // next state

  // ********************************************
  // entry selection
  // ********************************************
  // destination flag wins when both indicators rise together
  always_comb begin
    st_next = st_reg;
    st_next.prev_addr = core_addr;
    st_next.prev_paged = core_paged;
    cof_valid = |core_cof;
    if (core_cof[1]) begin
      cof_entry = {core_paged, core_addr};
    end else begin
      cof_entry = {st_reg.prev_paged, st_reg.prev_addr - TFC_BR_BACK};
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ### hdl/tfc_fifo.sv
// eight-word trace store: circular buffer with a saturating count
// assumes push, pop and clear are single-cycle strobes from the controller
`timescale 1ns/1ps
module tfc_fifo
  import tfc_pkg::*;
#(
  parameter int WIDTH = tfc_pkg::TFC_ENTRY_W,
  parameter int DEPTH = tfc_pkg::TFC_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  output logic [$clog2(DEPTH):0] count
);
  import tfc_pkg::*;
  localparam int PW = $clog2(DEPTH);

  // storage, pointers and count in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } tfc_fifo_st_t;

  tfc_fifo_st_t st_reg; // registered state
  tfc_fifo_st_t st_next; // next state
  logic full; // all words hold data

  // ********************************************
  // pointer and count update
  // ********************************************
  // a push when full drops the oldest word; pops never lower the count
  always_comb begin
    st_next = st_reg;
    full = (st_reg.cnt == (PW + 1)'(DEPTH));
    if (clear) begin
      st_next.wr = '0;
      st_next.rd = '0;
      st_next.cnt = '0;
    end else begin
      if (push) begin
        st_next.mem[st_reg.wr] = din;
        st_next.wr = st_reg.wr + 1'b1;
        if (!full) begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      // oldest slot advances on a read or on overwrite
      // a read that also overwrites when full still moves one slot only
      st_next.rd = st_reg.rd + PW'(pop | (push & full));
    end
  end

  assign dout = st_reg.mem[st_reg.rd];
  assign count = st_reg.cnt;

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ### hdl/tfc_trace_capture.sv
// trace capture controller of the on-chip debug unit, with apb registers
// assumes core flow indicators, comparator hits and trigger strobes arrive
// synchronous to pclk; sys_reset is a synchronous chip reset pulse
// Behaviour
// - trace buffer is eight-entry first-in-first-out
// - store flow addresses, event modes store data
// - event entries read zero high and extension
// - indirect jump, return, vector stores current address
// - taken branch stores previous address minus two
// - begin run stores from the trigger cycle until eight
// - end run captures until trigger, then disarms
// - end trigger on flow address is stored
// - low-byte read advances buffer, count stays only when full
// - count field shows captured valid entries
// - armed read returns oldest without shifting
// - idle low-byte read stores current address
// - each flow address store keeps 17-bit address and page
// - opcode trigger suppressed by coincident interrupt
// - fetch end trigger disarms, breaks despite interrupt
// - fetch begin trigger with interrupt keeps capturing
// - the unit never causes a chip reset
// - reset while enabled with begin bit clear clears arm, break only
// - other resets load comparator a reset vector
// - arming clears the three match flags
`timescale 1ns/1ps
module tfc_trace_capture
  import tfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tfc_pkg::TFC_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sys_reset,
  input wire logic [tfc_pkg::TFC_ADDR_W-1:0] core_addr,
  input wire logic core_paged,
  input wire logic [1:0] core_cof,
  input wire logic [7:0] core_data,
  input wire logic irq_pending,
  input wire logic a_hit,
  input wire logic b_hit,
  input wire logic trig_fetch,
  input wire logic trig_opcode,
  output logic [7:0] comp_a_ext,
  output logic [7:0] comp_a_high,
  output logic [7:0] comp_a_low,
  output logic [3:0] trig_mode,
  output logic tag_select,
  output logic trace_active_flag,
  output logic breakpoint_req
);
  import tfc_pkg::*;

  // ********************************************
  // state record
  // ********************************************
  typedef struct packed {
    logic [7:0] ca_ext; // comparator a extension byte
    logic [7:0] ca_high; // comparator a high byte
    logic [7:0] ca_low; // comparator a low byte
    logic [7:0] ctrl; // debug_control_reg
    logic [7:0] trig; // trigger_control_reg
    logic af; // comp_a_match_flag
    logic bf; // comp_b_match_flag
    logic cf; // third_status_flag
    tfc_run_t run; // run state, armed when not idle
    logic [31:0] prdata; // read data held for the bus
    logic pready; // access completes this cycle
    logic pslverr; // unmapped address answer
    logic brk; // one-cycle breakpoint request
  } tfc_st_t;

  tfc_st_t st_reg; // registered state
  tfc_st_t st_next; // next state

  // ********************************************
  // buffer and flow address helpers
  // ********************************************
  logic cof_valid; // core reports a change of flow
  logic [TFC_ENTRY_W-1:0] cof_entry; // address to store for it
  logic fifo_clear; // empty the buffer on arming
  logic fifo_push; // store one entry
  logic [TFC_ENTRY_W-1:0] fifo_din; // entry being stored
  logic fifo_pop; // advance past the oldest entry
  logic [TFC_ENTRY_W-1:0] fifo_dout; // oldest entry
  logic [TFC_CNT_W-1:0] fifo_count; // valid entries

  tfc_cof_addr u_cof (
    .pclk(pclk),
    .presetn(presetn),
    .core_addr(core_addr),
    .core_paged(core_paged),
    .core_cof(core_cof),
    .cof_valid(cof_valid),
    .cof_entry(cof_entry)
  );

  tfc_fifo #(
    .WIDTH(TFC_ENTRY_W),
    .DEPTH(TFC_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .clear(fifo_clear),
    .push(fifo_push),
    .din(fifo_din),
    .pop(fifo_pop),
    .dout(fifo_dout),
    .count(fifo_count)
  );

  // ********************************************
  // decoded terms
  // ********************************************
  logic access; // apb access phase
  logic done; // access ends at this edge
  logic enabled; // module_enable
  logic armed; // trace_active_flag value
  logic event_mode; // event-only trigger mode
  logic begin_type; // begin-trigger run
  logic trigger; // qualified trigger this cycle
  logic evt_store; // event data to store
  logic [7:0] rd_byte; // selected register byte
  logic rd_hit; // address decodes to a register

  // ********************************************
  // next-state logic
  // ********************************************
  always_comb begin
    st_next = st_reg;
    st_next.brk = 1'b0;
    fifo_clear = 1'b0;
    fifo_push = 1'b0;
    fifo_din = cof_entry;
    fifo_pop = 1'b0;
    access = psel & penable;
    done = access & st_reg.pready;
    // one wait state: ready rises on the second access cycle
    st_next.pready = access & ~st_reg.pready;
    enabled = st_reg.ctrl[TFC_CTRL_EN];
    armed = (st_reg.run != TFC_RUN_IDLE);
    event_mode = (st_reg.trig[3:0] == TFC_MODE_EVT_B) ||
                 (st_reg.trig[3:0] == TFC_MODE_A_EVT_B);
    // event modes always run as begin type whatever the begin bit says
    begin_type = st_reg.trig[TFC_TRIG_BEGIN] | event_mode;
    // opcode-qualified hits lose to a pending interrupt; fetch hits do not
    if (st_reg.trig[TFC_TRIG_SEL]) begin
      trigger = trig_opcode & ~irq_pending;
    end else begin
      trigger = trig_fetch;
    end
    evt_store = event_mode & b_hit;

    // register read mux, sampled one cycle before ready
    rd_hit = 1'b1;
    case (paddr)
      TFC_OFS_CA_EXT: rd_byte = st_reg.ca_ext;
      TFC_OFS_CA_HIGH: rd_byte = st_reg.ca_high;
      TFC_OFS_CA_LOW: rd_byte = st_reg.ca_low;
      // event entries hold zero above the data byte
      TFC_OFS_TR_EXT: rd_byte = {fifo_dout[17], 6'h00, fifo_dout[16]};
      TFC_OFS_TR_HIGH: rd_byte = fifo_dout[15:8];
      TFC_OFS_TR_LOW: rd_byte = fifo_dout[7:0];
      TFC_OFS_CTRL: rd_byte = st_reg.ctrl;
      TFC_OFS_TRIG: rd_byte = st_reg.trig;
      TFC_OFS_STAT: begin
        rd_byte = {st_reg.af, st_reg.bf, st_reg.cf, 4'h0, armed};
      end
      TFC_OFS_CNT: rd_byte = {4'h0, fifo_count};
      default: begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
    // error answer stands only in the completing cycle
    st_next.pslverr = 1'b0;
    if (access & ~st_reg.pready) begin
      st_next.prdata = {24'h000000, rd_byte};
      st_next.pslverr = ~rd_hit;
    end

    // register writes land at the completing edge
    if (done & pwrite) begin
      case (paddr)
        TFC_OFS_CA_EXT: st_next.ca_ext = pwdata[7:0];
        TFC_OFS_CA_HIGH: st_next.ca_high = pwdata[7:0];
        TFC_OFS_CA_LOW: st_next.ca_low = pwdata[7:0];
        TFC_OFS_CTRL: st_next.ctrl = pwdata[7:0];
        TFC_OFS_TRIG: st_next.trig = pwdata[7:0];
        // buffer, status and count are read only
        default: st_next.ctrl = st_next.ctrl;
      endcase
    end

    // low-byte reads: armed reads never shift, idle reads sample
    if (done & ~pwrite & (paddr == TFC_OFS_TR_LOW) & ~armed) begin
      fifo_pop = 1'b1;
      fifo_push = 1'b1;
      fifo_din = {core_paged, core_addr};
    end

    // comparator flags set only while a run is armed
    if (armed & a_hit) begin
      st_next.af = 1'b1;
    end
    if (armed & b_hit) begin
      st_next.bf = 1'b1;
    end

    // ********************************************
    // run sequencing
    // ********************************************
    case (st_reg.run)
      TFC_RUN_IDLE: begin
        // arming empties the buffer and clears the match flags
        if (enabled & st_reg.ctrl[TFC_CTRL_ARM]) begin
          fifo_clear = 1'b1;
          fifo_push = 1'b0;
          fifo_pop = 1'b0;
          st_next.af = 1'b0;
          st_next.bf = 1'b0;
          st_next.cf = 1'b0;
          st_next.run = begin_type ? TFC_RUN_WAIT : TFC_RUN_END;
        end
      end
      TFC_RUN_WAIT: begin
        // nothing stored until the trigger; the trigger cycle counts
        if (trigger) begin
          st_next.cf = 1'b1;
          st_next.run = TFC_RUN_FILL;
          if (event_mode) begin
            fifo_push = evt_store;
            fifo_din = {10'h000, core_data};
          end else begin
            fifo_push = cof_valid;
          end
        end
      end
      TFC_RUN_FILL: begin
        if (event_mode) begin
          fifo_push = evt_store;
          fifo_din = {10'h000, core_data};
        end else begin
          fifo_push = cof_valid;
        end
        // the eighth store ends the run and may request a break
        if (fifo_push & (fifo_count == TFC_CNT_W'(TFC_DEPTH - 1))) begin
          st_next.run = TFC_RUN_IDLE;
          st_next.ctrl[TFC_CTRL_ARM] = 1'b0;
          st_next.brk = st_reg.ctrl[TFC_CTRL_BRK];
        end
      end
      TFC_RUN_END: begin
        // capture continuously; the oldest word falls out when full
        fifo_push = cof_valid;
        if (trigger) begin
          st_next.cf = 1'b1;
          st_next.run = TFC_RUN_IDLE;
          st_next.ctrl[TFC_CTRL_ARM] = 1'b0;
          // halt request even when an interrupt is pending
          st_next.brk = st_reg.ctrl[TFC_CTRL_BRK];
        end
      end
      default: st_next.run = TFC_RUN_IDLE;
    endcase

    // disarm when software drops arm or enable
    if (armed & (~enabled | ~st_reg.ctrl[TFC_CTRL_ARM])) begin
      st_next.run = TFC_RUN_IDLE;
    end

    // ********************************************
    // chip reset handling
    // ********************************************
    // this block only reacts to resets; it has no reset output
    if (sys_reset) begin
      if (enabled & ~st_reg.trig[TFC_TRIG_BEGIN]) begin
        // enabled with begin bit clear, armed or not: keep results for the host
        st_next.ctrl[TFC_CTRL_ARM] = 1'b0;
        st_next.ctrl[TFC_CTRL_BRK] = 1'b0;
        st_next.run = TFC_RUN_IDLE;
      end else begin
        st_next.ca_ext = TFC_CA_EXT_RST;
        st_next.ca_high = TFC_CA_HIGH_RST;
        st_next.ca_low = TFC_CA_LOW_RST;
        st_next.ctrl = TFC_CTRL_RST;
        st_next.trig = TFC_TRIG_RST;
        st_next.af = 1'b0;
        st_next.bf = 1'b0;
        st_next.cf = 1'b0;
        st_next.run = TFC_RUN_IDLE;
      end
      st_next.brk = 1'b0;
      fifo_push = 1'b0;
      fifo_pop = 1'b0;
    end
  end

  // ********************************************
  // state register
  // ********************************************
  // power-on loads the default begin run aimed at the reset vector fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.ca_ext <= TFC_CA_EXT_RST;
      st_reg.ca_high <= TFC_CA_HIGH_RST;
      st_reg.ca_low <= TFC_CA_LOW_RST;
      st_reg.ctrl <= TFC_CTRL_RST;
      st_reg.trig <= TFC_TRIG_RST;
      st_reg.af <= 1'b0;
      st_reg.bf <= 1'b0;
      st_reg.cf <= 1'b0;
      st_reg.run <= TFC_RUN_IDLE;
      st_reg.prdata <= 32'h00000000;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.brk <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************
  // outputs straight from flip-flops, trace_active_flag decoded from the run state
  // ********************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign comp_a_ext = st_reg.ca_ext;
  assign comp_a_high = st_reg.ca_high;
  assign comp_a_low = st_reg.ca_low;
  assign trig_mode = st_reg.trig[3:0];
  assign tag_select = st_reg.ctrl[TFC_CTRL_TAG];
  assign trace_active_flag = (st_reg.run != TFC_RUN_IDLE);
  assign breakpoint_req = st_reg.brk;
endmodule

// ### tb/tfc_trace_capture_sva.sv
// port checker for the trace capture block: apb timing, reset defaults, arm
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps
module tfc_trace_capture_sva
  import tfc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tfc_pkg::TFC_PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] comp_a_ext,
  input wire logic [7:0] comp_a_high,
  input wire logic [7:0] comp_a_low,
  input wire logic [3:0] trig_mode,
  input wire logic trace_active_flag,
  input wire logic breakpoint_req
);
  // ********************************************
  // one domain, so one clock and one reset for all
  // ********************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // exactly one wait state after the setup cycle
  chk_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not on the second access cycle");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  chk_err_clean: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without ready or with data");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  // comparator a points at the reset vector fetch
  chk_reset_vector: assert property ($rose(presetn) |->
    comp_a_ext == 8'h00 && comp_a_high == 8'hFF && comp_a_low == 8'hFE)
    else $error("comparator a not at reset vector");
  // the default run arms itself one edge after release
  chk_default_arm: assert property ($rose(presetn) |=> trace_active_flag)
    else $error("default run not armed");
  // a breakpoint only follows the end of a run and lasts one cycle
  chk_brk_pulse: assert property (breakpoint_req |-> !trace_active_flag ##1 !breakpoint_req)
    else $error("breakpoint while armed or longer than a pulse");
  chk_disarm_write: assert property (psel && penable && pready && pwrite &&
    paddr == 8'h18 && !pwdata[6] |-> ##2 !trace_active_flag)
    else $error("armed flag kept after arm written low");
  chk_mode_write: assert property (psel && penable && pready && pwrite &&
    paddr == 8'h1C |=> trig_mode == $past(pwdata[3:0]))
    else $error("trigger mode not taken from write");
endmodule

// ### tb/tfc_core_model.sv
// core side model: address, flow indicators, data bus, hits and interrupts
// assumes the bench calls step right after a rising edge of pclk
`timescale 1ns/1ps
module tfc_core_model
  import tfc_pkg::*;
(
  input wire logic pclk,
  output logic [tfc_pkg::TFC_ADDR_W-1:0] core_addr,
  output logic core_paged,
  output logic [1:0] core_cof,
  output logic [7:0] core_data,
  output logic irq_pending,
  output logic a_hit,
  output logic b_hit,
  output logic trig_fetch,
  output logic trig_opcode
);
  // quiet core at time zero
  initial begin
    {core_addr, core_paged, core_cof, core_data} = '0;
    {irq_pending, a_hit, b_hit, trig_fetch, trig_opcode} = '0;
  end
  // one core cycle of activity, then one quiet cycle; address is held so
  // the next branch sees it as the previous registered address
  task automatic step(input logic [1:0] k, input logic [16:0] a, input logic pg,
                      input logic [7:0] d, input logic [3:0] ev);
    core_cof <= k;
    core_addr <= a;
    core_paged <= pg;
    core_data <= d;
    {trig_fetch, trig_opcode, irq_pending, b_hit} <= ev;
    a_hit <= ev[3];
    @(posedge pclk);
    core_cof <= 2'h0;
    {trig_fetch, trig_opcode, irq_pending, b_hit, a_hit} <= 5'h00;
    // released bus does not keep the old value
    core_data <= ~d;
    @(posedge pclk);
  endtask
endmodule

// ### tb/tfc_trace_capture_tb.sv
// self-checking bench: apb master, core model, queued read expectations
// assumes the design answers apb with one wait state
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module tfc_trace_capture_tb;
  import tfc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sys_reset, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [16:0] core_addr, cur_a;
  logic core_paged, irq_pending, a_hit, b_hit, trig_fetch, trig_opcode, cur_pg;
  logic [1:0] core_cof;
  logic [7:0] core_data;
  logic [32:0] ex; // expected {pslverr, prdata}
  logic [32:0] expq[$]; // pending read expectations
  logic [17:0] ent[$]; // entries the core produced
  int bad_count, samples_checked;
  tfc_trace_capture u_tfc_trace_capture (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_reset(sys_reset), .core_addr(core_addr),
    .core_paged(core_paged), .core_cof(core_cof), .core_data(core_data),
    .irq_pending(irq_pending), .a_hit(a_hit), .b_hit(b_hit), .trig_fetch(trig_fetch),
    .trig_opcode(trig_opcode), .comp_a_ext(), .comp_a_high(), .comp_a_low(),
    .trig_mode(), .tag_select(), .trace_active_flag(), .breakpoint_req());
  tfc_core_model u_tfc_core_model (.pclk(pclk), .core_addr(core_addr),
    .core_paged(core_paged), .core_cof(core_cof), .core_data(core_data),
    .irq_pending(irq_pending), .a_hit(a_hit), .b_hit(b_hit), .trig_fetch(trig_fetch),
    .trig_opcode(trig_opcode));
  // ********************************************
  // clock, watchdog, verdict
  // ********************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++; // run hung
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // ********************************************
  // apb master and read monitor
  // ********************************************
  // request held until pready is sampled high, then released a cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] r;
    r = xs();
    apb(1'b1, a, {r[31:8], v}); // upper bits are unused and random
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // extension, high, then the advancing low read
  task automatic rd_ent(input logic [17:0] e);
    rd(8'h0C, {25'h0, e[17], 6'h0, e[16]});
    rd(8'h10, {25'h0, e[15:8]});
    rd(8'h14, {25'h0, e[7:0]});
  endtask
  task automatic rd8(input int b);
    for (int i = 0; i < 8; i++) rd_ent(ent[b + i]);
  endtask
  // oldest expectation meets each completed read
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      ex = (expq.size() > 0) ? expq.pop_front() : 33'hX;
      `CHK("apb read", ex, {pslverr, prdata})
    end
  end
  // one core event with random address or data; st marks a captured one
  task automatic go(input logic [1:0] k, input logic [3:0] ev, input logic st);
    logic [31:0] r;
    logic [17:0] e;
    r = xs();
    e = (k == 2'b01) ? {cur_pg, cur_a - 17'h2} : {r[17], r[16:0]};
    if (k == 2'b00) e = {10'h0, r[31:24]};
    if (k == 2'b10) cur_pg = r[17];
    cur_a = r[16:0];
    if (st) ent.push_back(e);
    u_tfc_core_model.step(k, cur_a, cur_pg, r[31:24], ev);
  endtask
  task automatic sys_pulse();
    sys_reset <= 1'b1;
    @(posedge pclk);
    sys_reset <= 1'b0;
    @(posedge pclk);
  endtask
  // ********************************************
  // scenarios
  // ********************************************
  initial begin
    {presetn, psel, penable, pwrite, sys_reset, cur_pg} = '0;
    {paddr, pwdata, cur_a, bad_count, samples_checked} = '0;
    seed = 32'hFB9768F4;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // default begin run, waiting for a fetch hit on comparator a
    rd(8'h20, 33'h01);
    rd(8'h18, 33'hC0);
    rd(8'h1C, 33'h40);
    rd(8'h00, 33'h00);
    rd(8'h04, 33'hFF);
    rd(8'h08, 33'hFE);
    go(2'b10, 4'h0, 1'b0);
    go(2'b01, 4'h0, 1'b0);
    rd(8'h24, 33'h0);
    go(2'b10, 4'b1010, 1'b1);
    for (int i = 0; i < 9; i++) go({i[0], ~i[0]}, 4'h0, 1'b1);
    rd(8'h20, 33'hA0);
    rd(8'h24, 33'h08);
    rd8(0);
    rd(8'h24, 33'h08);
    rd_ent({cur_pg, cur_a});
    // end run with breakpoint, never paired with event modes
    ent.delete();
    wr(8'h1C, 8'h00);
    wr(8'h18, 8'hD0);
    go(2'b10, 4'h0, 1'b1);
    go(2'b01, 4'h0, 1'b1);
    go(2'b10, 4'h0, 1'b1);
    rd(8'h14, {25'h0, ent[0][7:0]});
    rd(8'h14, {25'h0, ent[0][7:0]});
    for (int i = 0; i < 7; i++) go({~i[0], i[0]}, 4'h0, 1'b1);
    go(2'b10, 4'b1010, 1'b1);
    sys_pulse();
    rd(8'h18, 33'h80);
    rd(8'h20, 33'hA0);
    rd(8'h24, 33'h08);
    rd8(3);
    // event only b, opcode qualified trigger
    ent.delete();
    wr(8'h1C, 8'hC3);
    wr(8'h18, 8'hC0);
    go(2'b00, 4'b0111, 1'b0);
    go(2'b00, 4'b0101, 1'b1);
    for (int i = 0; i < 7; i++) go(2'b00, 4'b0001, 1'b1);
    rd(8'h24, 33'h08);
    rd8(0);
    // chip reset outside an end run reloads the default run
    wr(8'h08, 8'h12);
    sys_pulse();
    rd(8'h08, 33'hFE);
    rd(8'h1C, 33'h40);
    rd(8'h18, 33'hC0);
    wr(8'h18, 8'h00);
    rd(8'h20, 33'h00);
    rd(8'h40, {1'b1, 32'h0});
    repeat (4) @(posedge pclk);
    final_report();
  end
endmodule
bind tfc_trace_capture tfc_trace_capture_sva u_tfc_trace_capture_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .comp_a_ext(comp_a_ext), .comp_a_high(comp_a_high), .comp_a_low(comp_a_low),
  .trig_mode(trig_mode), .trace_active_flag(trace_active_flag),
  .breakpoint_req(breakpoint_req));
